// File: src/wstx_fifo.sv
/*
 * Flip-flop FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two and one clock domain.
 */
module wstx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic not_full;
    } wstx_fifo_state_t;

    wstx_fifo_state_t st;
    wstx_fifo_state_t next_st;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Pointers and count
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        push = in_valid && st.not_full;
        pop = out_ready && (st.count != '0);
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        // Ready kept as a flop so the port has no logic behind it
        next_st.not_full = next_st.count != FULL;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{mem: '0, wr: '0, rd: '0, count: '0, not_full: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign in_ready = st.not_full;
    assign out_valid = st.count != '0;
    assign out_data = st.mem[st.rd];

    a_fifo_bounded: assert property (@(posedge clk) disable iff (!nrst)
        st.count <= FULL)
        else $error("fifo count beyond depth");

    c_fifo_full: cover property (@(posedge clk) disable iff (!nrst)
        !st.not_full);

endmodule : wstx_fifo

// File: src/wstx_pin_sync.sv
/*
 * Three-stage pin sampler with agreement filter.
 * Assumes inputs arrive asynchronously to clk.
 */
module wstx_pin_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } wstx_sync_state_t;

    wstx_sync_state_t st;
    wstx_sync_state_t next_st;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Stage one is never looked at here, only stages two and three
        next_st.level = (~(st.s2 ^ st.s3) & st.s3)
                        | ((st.s2 ^ st.s3) & st.level);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{s1: RST, s2: RST, s3: RST, level: RST};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

endmodule : wstx_pin_sync

// File: src/wstx_pkg.sv
/*
 * Constants shared by the serial transmit port of one WAN line.
 * Assumes a single core clock of 100 MHz that samples the line clock pin.
 */
// Behaviour
// - Launch each serial bit on line clock rise
// - Accept gapped line clock up to 52 MHz (the 100 MHz core samples too slowly to follow 52 MHz)
// - No new bit in blocked or missing period
// - Enable sampled one edge ahead of bit
// - Enable polarity chosen by line control setting
// - Sustain up to 52 Mbps on serial output (one bit per line clock rise; a 100 MHz core cannot follow a 52 MHz line clock)
// - X.86 mode: pin marks last bit of byte
package wstx_pkg;

    // ------------------------------------------------------------
    // Line control bits
    // ------------------------------------------------------------
    localparam int CTL_W = 2;
    localparam int CTL_POL_BIT = 0;
    localparam int CTL_X86_BIT = 1;

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int LEFT_W = 3;
    localparam logic [LEFT_W-1:0] BITS_AFTER_FIRST = 3'h7;
    localparam logic [LEFT_W-1:0] LAST_LEFT = 3'h1;
    localparam logic IDLE_LEVEL = 1'h1;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    localparam int PIN_W = 2;
    localparam int PIN_CLK = 0;
    localparam int PIN_EN = 1;
    localparam logic [PIN_W-1:0] PIN_RST = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Three-stage sampling needs several core cycles per line
    // half period; a full 52 MHz line clock wants a faster core.
    localparam int CLK_KHZ = 100000;
    localparam int LINE_MAX_KHZ = 52000;
    localparam int LINE_MIN_CYCLES = (CLK_KHZ + LINE_MAX_KHZ - 1)
                                     / LINE_MAX_KHZ;

endpackage : wstx_pkg

// File: src/wstx_tx_port.sv
/*
 * Transmit side of one serial WAN port: bytes from a FIFO are shifted
 * out LSB first, one bit per admitted rising edge of the line clock.
 * Assumes the line clock and enable pins are asynchronous to clk and
 * that the line control bits are static or set from the clk domain.
 */
module wstx_tx_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [wstx_pkg::CTL_W-1:0] tx_line_control_reg,
    input wire logic tx_line_clock_in,
    input wire logic tx_line_data_enable,
    output logic tx_byte_sync_out,
    output logic tx_byte_sync_oe,
    output logic tx_line_serial_out,
    input wire logic [wstx_pkg::BYTE_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);

    typedef struct packed {
        logic prev_clk;
        logic admit;
        logic busy;
        logic [wstx_pkg::LEFT_W-1:0] left;
        logic [wstx_pkg::BYTE_W-1:0] sh;
        logic serial;
        logic sync;
        logic oe;
    } wstx_port_state_t;

    wstx_port_state_t st;
    wstx_port_state_t next_st;

    logic [wstx_pkg::PIN_W-1:0] pin_lvl;
    logic clk_lvl;
    logic en_lvl;
    logic line_edge;
    logic x86;
    logic pol;
    logic pop;
    logic fifo_valid;
    logic [wstx_pkg::BYTE_W-1:0] fifo_data;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    // Clock and enable share one sampler so both see equal latency
    wstx_pin_sync #(
        .W(wstx_pkg::PIN_W),
        .RST(wstx_pkg::PIN_RST)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin({tx_line_data_enable, tx_line_clock_in}),
        .level(pin_lvl)
    );

    assign clk_lvl = pin_lvl[wstx_pkg::PIN_CLK];
    assign en_lvl = pin_lvl[wstx_pkg::PIN_EN];
    assign x86 = tx_line_control_reg[wstx_pkg::CTL_X86_BIT];
    assign pol = tx_line_control_reg[wstx_pkg::CTL_POL_BIT];

    // ------------------------------------------------------------
    // Byte buffer
    // ------------------------------------------------------------
    wstx_fifo #(
        .WIDTH(wstx_pkg::BYTE_W),
        .DEPTH(wstx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

    // ------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        pop = 1'b0;
        // A missing line clock period gives no edge and so no bit
        line_edge = clk_lvl && !st.prev_clk;
        next_st.prev_clk = clk_lvl;
        next_st.oe = x86;
        if (line_edge) begin
            // Outside X.86 mode, enable at this edge decides the next bit position; in X.86 mode every position is admitted
            if (x86) begin
                next_st.admit = 1'b1;
            end else begin
                next_st.admit = en_lvl == pol;
            end
            if (st.admit) begin
                next_st.sync = 1'b0;
                if (st.busy) begin
                    next_st.serial = st.sh[0];
                    next_st.sh = st.sh >> 1;
                    next_st.left = st.left - 1'b1;
                    if (st.left == wstx_pkg::LAST_LEFT) begin
                        next_st.busy = 1'b0;
                        next_st.sync = x86;
                    end
                end else if (fifo_valid) begin
                    // Refill on the same edge keeps bytes back to back
                    pop = 1'b1;
                    next_st.serial = fifo_data[0];
                    next_st.sh = fifo_data >> 1;
                    next_st.left = wstx_pkg::BITS_AFTER_FIRST;
                    next_st.busy = 1'b1;
                end else begin
                    // Underrun: line idles at mark, no byte counted
                    next_st.serial = wstx_pkg::IDLE_LEVEL;
                end
            end
            // Blocked period: serial and byte position hold
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{prev_clk: 1'b0, admit: 1'b1, busy: 1'b0,
                    left: '0, sh: '0, serial: wstx_pkg::IDLE_LEVEL,
                    sync: 1'b0, oe: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign tx_line_serial_out = st.serial;
    assign tx_byte_sync_out = st.sync;
    // Pin driven only in X.86 mode; otherwise it carries the framer's data enable
    assign tx_byte_sync_oe = st.oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_launch_on_edge: assert property (@(posedge clk) disable iff (!nrst)
        !line_edge |=> $stable(tx_line_serial_out))
        else $error("serial output moved without line clock rise");

    a_gap_no_bit: assert property (@(posedge clk) disable iff (!nrst)
        $stable(clk_lvl) |=> $stable(st.sh) && $stable(st.left))
        else $error("bit advanced during a gapped period");

    a_blocked_holds: assert property (@(posedge clk) disable iff (!nrst)
        line_edge && !st.admit |=> $stable(tx_line_serial_out)
            && $stable(st.sh) && $stable(st.busy))
        else $error("bit launched in a blocked period");

    a_enable_ahead: assert property (@(posedge clk) disable iff (!nrst)
        line_edge && !x86 |=> st.admit == $past(en_lvl == pol))
        else $error("enable not applied to the following bit");

    a_polarity_block: assert property (@(posedge clk) disable iff (!nrst)
        line_edge && !x86 && en_lvl != pol |=> !st.admit)
        else $error("inactive enable level did not block the bit");

    a_byte_load: assert property (@(posedge clk) disable iff (!nrst)
        pop |-> line_edge && st.admit && !st.busy
        ##1 st.busy && st.left == wstx_pkg::BITS_AFTER_FIRST)
        else $error("byte load at wrong moment or wrong count");

    a_sync_last_bit: assert property (@(posedge clk) disable iff (!nrst)
        $rose(tx_byte_sync_out) |-> !st.busy && st.left == '0
            && tx_byte_sync_oe && $past(st.left) == wstx_pkg::LAST_LEFT)
        else $error("byte sync not on last bit of byte");

    a_sync_mode_only: assert property (@(posedge clk) disable iff (!nrst)
        !x86 |=> !tx_byte_sync_oe && !tx_byte_sync_out)
        else $error("byte sync driven outside X.86 mode");

    a_drive_follows: assert property (@(posedge clk) disable iff (!nrst)
        x86 ##1 x86 |-> tx_byte_sync_oe)
        else $error("byte sync pin not driven in X.86 mode");

    c_byte_sent: cover property (@(posedge clk) disable iff (!nrst)
        pop ##[1:300] $fell(st.busy));

    c_blocked_edge: cover property (@(posedge clk) disable iff (!nrst)
        line_edge && !st.admit && st.busy);

    c_sync_pulse: cover property (@(posedge clk) disable iff (!nrst)
        $rose(tx_byte_sync_out));

    c_back_to_back: cover property (@(posedge clk) disable iff (!nrst)
        $fell(st.busy) ##[1:40] pop);

endmodule : wstx_tx_port

// File: test/tb.sv
/*
 * Self-checking bench for the serial transmit port.
 * Assumes the framer model in wstx_framer_model.sv.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, nrst, tx_valid, run, gap_on, blk_on, tx_ready;
    logic line_clk, fr_en, pin, ser, sync, sync_oe;
    logic [1:0] ctl;
    logic [7:0] tx_data;
    int err_count, samples_checked;
    int cycles = 0;
    logic [7:0] q[$];
    // Released pin follows the framer enable, or the board pull-up in X.86 mode
    assign pin = sync_oe ? sync : (ctl[1] ? 1'b1 : fr_en);
    wstx_tx_port dut_u (.clk(clk), .nrst(nrst),
        .tx_line_control_reg(ctl), .tx_line_clock_in(line_clk),
        .tx_line_data_enable(pin), .tx_byte_sync_out(sync),
        .tx_byte_sync_oe(sync_oe), .tx_line_serial_out(ser),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    wstx_framer_model fr_u (.nrst(nrst), .run(run), .gap_on(gap_on),
        .blk_on(blk_on), .pol(ctl[0]), .x86(ctl[1]), .ser(ser),
        .sync(sync), .line_clk(line_clk), .en(fr_en));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    // ------
    // Tasks
    // ------
    task chk(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task do_reset(input logic [1:0] c);
        nrst = 1'b0;
        ctl = c;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
    endtask : do_reset
    task push(input logic [7:0] b);
        int n;
        n = 0;
        tx_data = b;
        tx_valid = 1'b1;
        q.push_back(b);
        while (tx_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
    endtask : push
    task send(input int nb, input string name);
        int n;
        logic [7:0] b;
        logic e;
        tx_valid = 1'b0;
        fr_u.bits.delete();
        run = 1'b1;
        n = 0;
        while (fr_u.bits.size() < nb * 8 && n < 15000) begin
            @(negedge clk);
            n++;
        end
        run = 1'b0;
        repeat (30) @(negedge clk);
        for (int i = 0; i < nb * 8; i++) begin
            b = (q.size() > 0) ? q[0] : 8'hff;
            e = (i % 8 == 7) && (q.size() > 0);
            chk({7'h0, b[i % 8]}, {7'h0, fr_u.bits[i][0]});
            if (ctl[1]) chk({7'h0, e}, {7'h0, fr_u.bits[i][1]});
            if (i % 8 == 7 && q.size() > 0) void'(q.pop_front());
        end
        $display("test %s done", name);
    endtask : send
    // ------
    // Scenarios
    // ------
    task t_basic();
        push(8'ha5);
        push(8'h3c);
        send(2, "basic");
    endtask : t_basic
    task t_gap();
        gap_on = 1'b1;
        push(8'h81);
        push(8'h7e);
        send(2, "gap");
        gap_on = 1'b0;
    endtask : t_gap
    task t_block(input logic [1:0] c);
        if (c != ctl) do_reset(c);
        blk_on = 1'b1;
        push(8'h96);
        push(8'h0f);
        send(2, "block");
        blk_on = 1'b0;
    endtask : t_block
    task t_fifo();
        for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
        tx_valid = 1'b0;
        repeat (3) @(negedge clk);
        chk(8'h0, {7'h0, tx_ready});
        tx_data = 8'hee;
        tx_valid = 1'b1;
        repeat (5) @(negedge clk);
        chk(8'h0, {7'h0, tx_ready});
        send(9, "fifo");
        chk(8'h1, {7'h0, tx_ready});
    endtask : t_fifo
    task t_x86();
        do_reset(2'h2);
        chk(8'h1, {7'h0, sync_oe});
        push(8'h6b);
        push(8'hd2);
        send(2, "x86");
    endtask : t_x86
    initial begin
        nrst = 1'b0;
        ctl = 2'h1;
        tx_valid = 1'b0;
        tx_data = 8'h0;
        run = 1'b0;
        gap_on = 1'b0;
        blk_on = 1'b0;
        err_count = 0;
        samples_checked = 0;
        @(negedge clk);
        do_reset(2'h1);
        t_basic();
        t_gap();
        t_block(2'h1);
        t_fifo();
        t_block(2'h0);
        t_x86();
        summarize();
    end
endmodule : tb

// File: test/wstx_framer_model.sv
/*
 * Far-end framer: gapped line clock, data enable, bit capture.
 * Assumes the bench resolves the shared enable pin.
 */
module wstx_framer_model (
    input wire logic nrst,
    input wire logic run,
    input wire logic gap_on,
    input wire logic blk_on,
    input wire logic pol,
    input wire logic x86,
    input wire logic ser,
    input wire logic sync,
    output logic line_clk,
    output logic en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] bits[$];
    logic admit;
    logic blk;
    int cnt;
    assign en = pol ^ blk;
    always @(negedge nrst) admit = 1'b1;
    initial begin
        line_clk = 1'b0;
        blk = 1'b0;
        admit = 1'b1;
        cnt = 0;
        forever begin
            #62.5;
            cnt++;
            if (run && !(gap_on && cnt[0])) begin
                line_clk = 1'b1;
                #62.5;
                // Clock stands low between frames
                line_clk = 1'b0;
                if (admit) bits.push_back({sync, ser});
                admit = x86 || !blk;
                blk = blk_on && (cnt % 3 == 0);
            end else begin
                #62.5;
            end
        end
    end
endmodule : wstx_framer_model
